// file: strec_pkg.sv
package strec_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_MODE = 16'h251C;
  localparam logic [15:0] IDX_TOTAL_LO = 16'h2710;
  localparam logic [15:0] IDX_TOTAL_HI = 16'h2711;
  localparam logic [15:0] IDX_SEGLEN_LO = 16'h271A;
  localparam logic [15:0] IDX_SEGLEN_HI = 16'h271B;
  localparam logic [15:0] IDX_REPEAT = 16'h2724;
  localparam logic [15:0] IDX_POST_LO = 16'h2774;
  localparam logic [15:0] IDX_POST_HI = 16'h2775;
  localparam logic [15:0] IDX_CTRL = 16'h27D8;
  localparam logic [15:0] IDX_RATE = 16'h27D9;
  localparam logic [15:0] IDX_STATUS = 16'h27E2;
  localparam logic [15:0] IDX_SEGS_DONE = 16'h27E3;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam logic [31:0] STANDARD_SEGMENTED_CODE = 32'h0000_0002;
  localparam logic [31:0] STREAMING_SEGMENTED_CODE = 32'h0000_0020;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_CHAN_LSB = 2;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_CFGERR_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values, limits and sizes
  // ----------------------------------------------------------------
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [63:0] LEN_RESET = 64'h0000_0000_0000_0000;
  localparam logic [15:0] RATE_RESET = 16'h0000;
  localparam logic [15:0] INTERLACE_RATE_MSPS = 16'h0064;
  localparam logic [63:0] MEM_SAMPLES = 64'h0000_0000_0400_0000;
  localparam logic [63:0] MIN_MEM_SAMPLES = 64'h0000_0000_0000_0008;
  localparam logic [63:0] MIN_POST_SAMPLES = 64'h0000_0000_0000_0004;

  // Acquisition sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_PREFILL = 5'b0_0010,
    ST_WAIT_TRIG = 5'b0_0100,
    ST_POST = 5'b0_1000,
    ST_REARM = 5'b1_0000
  } strec_state_t;

endpackage

// file: strec_sync2.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Two-stage level synchroniser
// ------------------------------------------------------------------
module strec_sync2 (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Level
  input wire logic async_i,
  output logic sync_o
);

  logic meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

`default_nettype wire

// file: strec_top.sv
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module strec_top
  import strec_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Converter samples and trigger pin
  input wire logic adc_valid_i,
  input wire logic [15:0] adc_data_i,
  input wire logic trigger_i,
  // Sample memory write port
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [15:0] mem_data_o,
  output logic [1:0] mem_be_o,
  // Completed segment stream notice and run status
  output logic seg_ready_o,
  output logic [31:0] seg_base_o,
  output logic [31:0] seg_first_o,
  output logic running_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  strec_state_t st_q;
  logic [31:0] mode_q;
  logic [63:0] total_q, seglen_q, post_q;
  logic [31:0] repeat_q, segs_done_q;
  logic [15:0] rate_q;
  logic [1:0] chan_q;
  logic dph_q, dph_wr_q;
  logic [15:0] dph_idx_q;
  logic start_w, stop_w, cfg_err_w, interlace_w, mode_std_w, mode_fifo_w;
  logic trig_sync, trig_prev_q, trig_edge_w;
  logic [63:0] pre_w, step_w, mem_share_w, wptr_q, wptr_next_w;
  logic [63:0] fill_q, postcnt_q, stored_q;
  logic [31:0] base_q, base_next_w;
  logic writing_w, sample_w, seg_done_w, last_seg_w;
  logic [15:0] addr_idx_w;
  logic [31:0] rd_w;

  // ----------------------------------------------------------------
  // Trigger pin synchronisation and edge detect
  // ----------------------------------------------------------------
  strec_sync2 u_trig_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i(trigger_i),
    .sync_o(trig_sync)
  );

  // Edge is taken from the second stage only
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_sync;
    end
  end
  assign trig_edge_w = trig_sync & ~trig_prev_q;

  // ----------------------------------------------------------------
  // AHB-Lite address phase capture
  // ----------------------------------------------------------------
  assign addr_idx_w = haddr_i[17:2];

  // Zero wait state slave, data phase follows a taken address phase
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      dph_q <= 1'b0;
      dph_wr_q <= 1'b0;
      dph_idx_q <= 16'h0000;
    end else begin
      dph_q <= hsel_i & htrans_i[1] & hready_i;
      dph_wr_q <= hsel_i & htrans_i[1] & hready_i & hwrite_i;
      dph_idx_q <= addr_idx_w;
    end
  end

  // Always ready, always OKAY
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Whole-word writes only; hsize is not decoded
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mode_q <= MODE_RESET;
      total_q <= LEN_RESET;
      seglen_q <= LEN_RESET;
      post_q <= LEN_RESET;
      repeat_q <= 32'h0000_0000;
      rate_q <= RATE_RESET;
      chan_q <= 2'b00;
    end else if (dph_wr_q) begin
      case (dph_idx_q)
        IDX_MODE: mode_q <= hwdata_i;
        IDX_TOTAL_LO: total_q[31:0] <= hwdata_i;
        IDX_TOTAL_HI: total_q[63:32] <= hwdata_i;
        IDX_SEGLEN_LO: seglen_q[31:0] <= hwdata_i;
        IDX_SEGLEN_HI: seglen_q[63:32] <= hwdata_i;
        IDX_POST_LO: post_q[31:0] <= hwdata_i;
        IDX_POST_HI: post_q[63:32] <= hwdata_i;
        IDX_REPEAT: repeat_q <= hwdata_i;
        IDX_RATE: rate_q <= hwdata_i[15:0];
        IDX_CTRL: chan_q <= hwdata_i[CTRL_CHAN_LSB+1:CTRL_CHAN_LSB];
        default: mode_q <= mode_q;
      endcase
    end
  end

  // Start and stop are write pulses, not stored bits
  assign start_w = dph_wr_q & (dph_idx_q == IDX_CTRL) &
                   hwdata_i[CTRL_START_BIT];
  assign stop_w = dph_wr_q & (dph_idx_q == IDX_CTRL) &
                  hwdata_i[CTRL_STOP_BIT];

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb begin
    case (addr_idx_w)
      IDX_MODE: rd_w = mode_q;
      IDX_TOTAL_LO: rd_w = total_q[31:0];
      IDX_TOTAL_HI: rd_w = total_q[63:32];
      IDX_SEGLEN_LO: rd_w = seglen_q[31:0];
      IDX_SEGLEN_HI: rd_w = seglen_q[63:32];
      IDX_POST_LO: rd_w = post_q[31:0];
      IDX_POST_HI: rd_w = post_q[63:32];
      IDX_REPEAT: rd_w = repeat_q;
      IDX_RATE: rd_w = {16'h0000, rate_q};
      IDX_CTRL: rd_w = {28'h000_0000, chan_q, 2'b00};
      IDX_STATUS: rd_w = {30'h0000_0000, cfg_err_w, running_o};
      IDX_SEGS_DONE: rd_w = segs_done_q;
      default: rd_w = 32'h0000_0000;
    endcase
  end

  // Read data is latched at the address phase for the data phase
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (hsel_i & htrans_i[1] & hready_i & ~hwrite_i) begin
      hrdata_o <= rd_w;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode and limits
  // ----------------------------------------------------------------
  assign mode_std_w = (mode_q == STANDARD_SEGMENTED_CODE);
  assign mode_fifo_w = (mode_q == STREAMING_SEGMENTED_CODE);
  assign interlace_w = (rate_q > INTERLACE_RATE_MSPS);
  assign step_w = interlace_w ? 64'h0000_0000_0000_0002 :
                                64'h0000_0000_0000_0001;
  assign pre_w = seglen_q - post_q;
  // Per-channel memory share: 1, 2, 4 or 8 channels
  assign mem_share_w = MEM_SAMPLES >> chan_q;

  // Fixed minima do not depend on channels or memory
  always_comb begin
    cfg_err_w = 1'b0;
    if (!(mode_std_w | mode_fifo_w)) begin
      cfg_err_w = 1'b1;
    end
    if (post_q < MIN_POST_SAMPLES || post_q > seglen_q) begin
      cfg_err_w = 1'b1;
    end
    if (mode_std_w && (total_q < MIN_MEM_SAMPLES ||
                       total_q > mem_share_w ||
                       seglen_q > (mem_share_w >> 1))) begin
      cfg_err_w = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Segment ring pointer and completion
  // ----------------------------------------------------------------
  assign writing_w = (st_q == ST_PREFILL) | (st_q == ST_WAIT_TRIG) |
                     (st_q == ST_POST);
  assign sample_w = writing_w & adc_valid_i;
  // Pre-trigger data wraps inside its own segment
  assign wptr_next_w = (wptr_q + step_w >= seglen_q) ?
                       wptr_q + step_w - seglen_q : wptr_q + step_w;
  assign seg_done_w = (st_q == ST_POST) & adc_valid_i &
                      (postcnt_q + step_w >= post_q);
  assign last_seg_w = mode_std_w ? (stored_q + seglen_q >= total_q) :
                      (repeat_q != 32'h0000_0000 &&
                       segs_done_q + 32'h0000_0001 == repeat_q);
  // Equal segments laid back to back; streaming wraps the memory
  assign base_next_w = (mode_fifo_w &&
      {32'h0000_0000, base_q} + (seglen_q << 1) > MEM_SAMPLES) ?
      32'h0000_0000 : base_q + seglen_q[31:0];

  // ----------------------------------------------------------------
  // Acquisition sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
    end else if (stop_w) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start_w && !cfg_err_w) begin
            st_q <= (pre_w == LEN_RESET) ? ST_WAIT_TRIG : ST_PREFILL;
          end
        end
        ST_PREFILL: begin
          if (adc_valid_i && fill_q + step_w >= pre_w) begin
            st_q <= ST_WAIT_TRIG;
          end
        end
        ST_WAIT_TRIG: begin
          if (trig_edge_w) begin
            st_q <= ST_POST;
          end
        end
        ST_POST: begin
          // Triggers here change nothing
          if (seg_done_w) begin
            st_q <= last_seg_w ? ST_IDLE : ST_REARM;
          end
        end
        ST_REARM: begin
          // One-cycle gap, then armed again
          st_q <= (pre_w == LEN_RESET) ? ST_WAIT_TRIG : ST_PREFILL;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Sample counters per segment
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wptr_q <= LEN_RESET;
      fill_q <= LEN_RESET;
      postcnt_q <= LEN_RESET;
    end else if (!writing_w) begin
      wptr_q <= LEN_RESET;
      fill_q <= LEN_RESET;
      postcnt_q <= LEN_RESET;
    end else if (adc_valid_i) begin
      wptr_q <= wptr_next_w;
      fill_q <= fill_q + step_w;
      if (st_q == ST_POST) begin
        postcnt_q <= postcnt_q + step_w;
      end
    end
  end

  // Segment base, totals and done count
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      base_q <= 32'h0000_0000;
      stored_q <= LEN_RESET;
      segs_done_q <= 32'h0000_0000;
    end else if (st_q == ST_IDLE && start_w && !cfg_err_w) begin
      base_q <= 32'h0000_0000;
      stored_q <= LEN_RESET;
      segs_done_q <= 32'h0000_0000;
    end else if (seg_done_w) begin
      base_q <= base_next_w;
      stored_q <= stored_q + seglen_q;
      segs_done_q <= segs_done_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Memory write port, stream notice and run status
  // ----------------------------------------------------------------
  // One byte per sample; interlace writes both converter bytes
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mem_we_o <= 1'b0;
      mem_addr_o <= 32'h0000_0000;
      mem_data_o <= 16'h0000;
      mem_be_o <= 2'b00;
    end else begin
      mem_we_o <= sample_w;
      mem_addr_o <= base_q + wptr_q[31:0];
      mem_data_o <= adc_data_i;
      mem_be_o <= interlace_w ? 2'b11 : 2'b01;
    end
  end

  // Only finished segments are announced to the streaming side
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      seg_ready_o <= 1'b0;
      seg_base_o <= 32'h0000_0000;
      seg_first_o <= 32'h0000_0000;
      running_o <= 1'b0;
    end else begin
      seg_ready_o <= seg_done_w & mode_fifo_w;
      if (seg_done_w) begin
        seg_base_o <= base_q;
        seg_first_o <= wptr_next_w[31:0];
      end
      running_o <= (st_q != ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_trig_starts_post: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (st_q == ST_WAIT_TRIG && trig_edge_w && !stop_w) |=> st_q == ST_POST)
    else $error("trigger did not start post phase");

  chk_post_ignores_trig: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (st_q == ST_POST && trig_edge_w && !seg_done_w && !stop_w)
    |=> st_q == ST_POST)
    else $error("trigger disturbed a filling segment");

  chk_rearm_gap_short: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (st_q == ST_REARM && !stop_w)
    |=> (st_q == ST_PREFILL || st_q == ST_WAIT_TRIG))
    else $error("re-arm gap too long");

  chk_std_total_end: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (seg_done_w && mode_std_w && stored_q + seglen_q >= total_q)
    |=> st_q == ST_IDLE ##1 (st_q == ST_IDLE || $past(start_w)))
    else $error("standard run did not end at total");

  chk_fifo_count_end: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (seg_done_w && mode_fifo_w && repeat_q != 32'h0000_0000 &&
     segs_done_q + 32'h0000_0001 == repeat_q) |=> st_q == ST_IDLE)
    else $error("streaming run overran its segment count");

  chk_fifo_endless: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (seg_done_w && mode_fifo_w && repeat_q == 32'h0000_0000 && !stop_w)
    |=> st_q == ST_REARM ##1 (st_q != ST_IDLE || $past(stop_w)))
    else $error("endless streaming stopped");

  chk_seg_notice: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (seg_done_w && mode_fifo_w) |=> seg_ready_o && seg_base_o == $past(base_q))
    else $error("segment notice missing or wrong base");

  chk_write_follows: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (adc_valid_i && st_q == ST_WAIT_TRIG)
    |=> mem_we_o && mem_data_o == $past(adc_data_i))
    else $error("armed sample not written");

  chk_interlace_lanes: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (mem_we_o && $past(rate_q) > INTERLACE_RATE_MSPS) |-> mem_be_o == 2'b11)
    else $error("interlace write lost a converter byte");

  chk_mode_codes: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (st_q == ST_IDLE && start_w && !mode_std_w && !mode_fifo_w)
    |=> st_q == ST_IDLE)
    else $error("started with an unknown mode code");

endmodule

`default_nettype wire

// file: strec_adc_model.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Converter and sample memory model
// ------------------------------------------------------------------
module strec_adc_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Pacing: high gives a beat every other cycle
  input wire logic slow_i,
  // Converter side
  output logic adc_valid_o,
  output logic [15:0] adc_data_o,
  // Memory side
  input wire logic mem_we_i,
  input wire logic [1:0] mem_be_i,
  output logic [31:0] wr_count_o,
  output logic [1:0] last_be_o
);
  logic phase_q;

  // Beats; data moves every cycle so idle beats never look valid
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      phase_q <= 1'b0;
      adc_valid_o <= 1'b0;
      adc_data_o <= 16'h0000;
    end else begin
      phase_q <= ~phase_q;
      adc_valid_o <= ~slow_i | phase_q;
      adc_data_o <= adc_data_o + 16'h0101; // Two lanes
    end
  end

  // Memory counts writes and keeps the lanes of the last one
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_count_o <= 32'h0000_0000;
      last_be_o <= 2'b00;
    end else if (mem_we_i) begin
      wr_count_o <= wr_count_o + 32'h0000_0001;
      last_be_o <= mem_be_i; // One or both byte lanes per sample
    end
  end
endmodule

`default_nettype wire

// file: strec_top_tb.sv
`timescale 1ns/10ps
`default_nettype none

module strec_top_tb;
  import strec_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys_i, rst_i, hwrite_i, hready_i, trigger_i, slow;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, mem_addr_o, seg_base_o;
  logic [31:0] seg_first_o, wr_count, last_base, max_addr, rd, last_addr;
  logic [1:0] htrans_i, mem_be_o, last_be;
  logic [15:0] adc_data_i, mem_data_o;
  logic hreadyout_o, hresp_o, adc_valid_i, mem_we_o, seg_ready_o;
  logic running_o;
  int miscompares, cmp_count, seg_pulses;

  strec_top u_strec_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .hsel_i(1'b1), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(3'b010), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .adc_valid_i(adc_valid_i), .adc_data_i(adc_data_i),
    .trigger_i(trigger_i), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
    .mem_be_o(mem_be_o), .seg_ready_o(seg_ready_o),
    .seg_base_o(seg_base_o), .seg_first_o(seg_first_o),
    .running_o(running_o));

  strec_adc_model u_strec_adc_model (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .slow_i(slow), .adc_valid_o(adc_valid_i),
    .adc_data_o(adc_data_i), .mem_we_i(mem_we_o),
    .mem_be_i(mem_be_o), .wr_count_o(wr_count), .last_be_o(last_be));

  // Single slave, so its ready is the bus ready
  assign hready_i = hreadyout_o;

  // ----------------------------------------------------------------
  // Clock, watchdog and monitors
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    repeat (30000) @(posedge clk_sys_i);
    miscompares = miscompares + 1;
    give_verdict();
  end

  // Segment notices and highest written address
  always @(posedge clk_sys_i) begin
    if (seg_ready_o === 1'b1) begin
      seg_pulses <= seg_pulses + 1;
      last_base <= seg_base_o;
      last_addr <= mem_addr_o;
    end
    if (mem_we_o === 1'b1 && mem_addr_o > max_addr) max_addr <= mem_addr_o;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Address phase held until ready, then data phase held until ready
  task automatic bus(input logic [15:0] idx, input logic wr,
                     input logic [31:0] d, output logic [31:0] q);
    haddr_i <= {14'h0000, idx, 2'b00};
    htrans_i <= 2'b10;
    hwrite_i <= wr;
    @(posedge clk_sys_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
    htrans_i <= 2'b00;
    hwdata_i <= d;
    @(posedge clk_sys_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
    q = hrdata_o;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(idx, 1'b1, d, q);
  endtask

  task automatic rdr(input logic [15:0] idx);
    bus(idx, 1'b0, 32'h0000_0000, rd);
  endtask

  // Design derives pre as seg minus post, keeps steps
  task automatic cfg(input logic [31:0] mode, input logic [31:0] seg,
                     input logic [31:0] post, input logic [31:0] tot,
                     input logic [31:0] rep, input logic [31:0] rate);
    wr(IDX_MODE, mode);
    wr(IDX_TOTAL_LO, tot);
    wr(IDX_TOTAL_HI, 32'h0000_0000);
    wr(IDX_SEGLEN_LO, seg);
    wr(IDX_SEGLEN_HI, 32'h0000_0000);
    wr(IDX_POST_LO, post);
    wr(IDX_POST_HI, 32'h0000_0000);
    wr(IDX_REPEAT, rep);
    wr(IDX_RATE, rate);
    seg_pulses = 0;
    max_addr = 32'h0000_0000;
    wr(IDX_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk_sys_i);
  endtask

  // Pulse long enough to pass the two-stage synchroniser
  task automatic pulse;
    trigger_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    trigger_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
  endtask

  // Trigger at a steady pace until the sequencer goes idle
  task automatic run_out;
    for (int i = 0; i < 40 && running_o !== 1'b0; i++) begin
      repeat (14) @(posedge clk_sys_i);
      pulse();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check({31'h0, hreadyout_o}, 32'h0000_0001);
    check({31'h0, hresp_o}, 32'h0000_0000);
    rdr(IDX_MODE);
    check(rd, MODE_RESET);
    wr(16'h1234, 32'hDEAD_BEEF);
    rdr(16'h1234);
    check(rd, 32'h0000_0000);
  endtask

  // Unknown mode code refuses start and flags a config error
  task automatic t_bad_mode;
    cfg(32'h0000_0005, 32'h0000_0008, 32'h0000_0004, 32'h0000_0010,
        32'h0000_0000, 32'h0000_0000);
    check({31'h0, running_o}, 32'h0000_0000);
    rdr(IDX_STATUS);
    check(rd[1:0], 2'b10);
  endtask

  task automatic t_standard;
    cfg(STANDARD_SEGMENTED_CODE, 32'h0000_0008, 32'h0000_0004,
        32'h0000_0010, 32'h0000_0000, 32'h0000_0000);
    check({31'h0, running_o}, 32'h0000_0001);
    run_out();
    check({31'h0, running_o}, 32'h0000_0000);
    rdr(IDX_SEGS_DONE);
    check(rd, 32'h0000_0002);
    check(seg_pulses, 0);
    check(max_addr, 32'h0000_000F);
    check(last_be, 2'b01);
  endtask

  task automatic t_stream;
    cfg(STREAMING_SEGMENTED_CODE, 32'h0000_0008, 32'h0000_0004,
        32'h0000_0000, 32'h0000_0003, 32'h0000_0000);
    run_out();
    check(seg_pulses, 3);
    check(last_base, 32'h0000_0010);
    // Oldest sample sits just after the newest one in the ring
    check(seg_first_o, (last_addr + 32'h0000_0001) & 32'h0000_0007);
    rdr(IDX_SEGS_DONE);
    check(rd, 32'h0000_0003);
  endtask

  // Second edge lands in the post phase and must not count
  task automatic t_ignore;
    cfg(STREAMING_SEGMENTED_CODE, 32'h0000_0010, 32'h0000_000C,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    repeat (10) @(posedge clk_sys_i);
    pulse();
    pulse();
    repeat (40) @(posedge clk_sys_i);
    rdr(IDX_SEGS_DONE);
    check(rd, 32'h0000_0001);
    check({31'h0, running_o}, 32'h0000_0001);
    wr(IDX_CTRL, 32'h0000_0002);
    repeat (3) @(posedge clk_sys_i);
    check({31'h0, running_o}, 32'h0000_0000);
  endtask

  // Above the interlace rate each beat carries two converter bytes
  task automatic t_interlace;
    slow <= 1'b1;
    cfg(STREAMING_SEGMENTED_CODE, 32'h0000_0010, 32'h0000_0008,
        32'h0000_0000, 32'h0000_0001, 32'h0000_00C8);
    run_out();
    check(seg_pulses, 1);
    check(last_be, 2'b11);
    slow <= 1'b0;
  endtask

  task automatic give_verdict;
    $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    miscompares = 0;
    cmp_count = 0;
    seg_pulses = 0;
    last_base = 32'h0000_0000;
    max_addr = 32'h0000_0000;
    rst_i = 1'b1;
    slow = 1'b0;
    trigger_i = 1'b0;
    haddr_i = 32'h0000_0000;
    htrans_i = 2'b00;
    hwrite_i = 1'b0;
    hwdata_i = 32'h0000_0000;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_reset();
    t_bad_mode();
    t_standard();
    t_stream();
    t_ignore();
    t_interlace();
    give_verdict();
  end
endmodule

`default_nettype wire
